// *** shared/psbp_pkg.sv ***
/*
 * constants for the phase-shifted bridge gate-drive generator:
 * register offsets, field positions, reset values, timing counts.
 * assumes a 40 mhz apb clock shared by the bus and the pwm logic.
 */
package psbp_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PSBP_CLK_PERIOD_PS   = 25000;     // 40 mhz clock
   localparam int PSBP_SW_PERIOD_PS    = 10000000;  // 10 us switching
   localparam int PSBP_PERIOD_CYC      =
      PSBP_SW_PERIOD_PS / PSBP_CLK_PERIOD_PS;
   localparam int PSBP_CW              = 16;        // counter width

   // ****************************************************************
   // register map, byte offsets
   // ****************************************************************
   localparam logic [7:0] PSBP_OFF_CTRL   = 8'h00;
   localparam logic [7:0] PSBP_OFF_PHASE  = 8'h04;
   localparam logic [7:0] PSBP_OFF_DB_AP  = 8'h08;
   localparam logic [7:0] PSBP_OFF_DB_PA  = 8'h0c;
   localparam logic [7:0] PSBP_OFF_STATUS = 8'h10;
   localparam logic [7:0] PSBP_OFF_RCNT   = 8'h14;

   // ctrl fields
   localparam int PSBP_CTRL_EN_BIT   = 0;
   localparam int PSBP_CTRL_MODE_LSB = 1;
   // status fields
   localparam int PSBP_STAT_MODE_LSB = 0;
   localparam int PSBP_STAT_RUN_BIT  = 2;
   localparam int PSBP_STAT_CNT_LSB  = 16;

   // reset values
   localparam logic [15:0] PSBP_RST_PHASE = 16'h0000;
   localparam logic [15:0] PSBP_RST_DB    = 16'h0008;

   // rectifier gating modes
   localparam logic [1:0] PSBP_RECT_OFF   = 2'h0;
   localparam logic [1:0] PSBP_RECT_DIODE = 2'h1;
   localparam logic [1:0] PSBP_RECT_FULL  = 2'h2;

endpackage : psbp_pkg

// *** core/psbp_core.sv ***
/*
 * phase-shifted full-bridge gate-drive generator with apb registers.
 * drives two bridge legs and two rectifier switches from one clock.
 * assumes an apb master on pclk and gate drivers behind the outputs.
 */
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module psbp_core
   import psbp_pkg::*;
#(
   parameter logic [15:0] PERIOD_CYC = 16'(PSBP_PERIOD_CYC)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             end_leg_drive_a,
   output logic             end_leg_drive_b,
   output logic             start_leg_drive_a,
   output logic             start_leg_drive_b,
   output logic             rect_drive_a,
   output logic             rect_drive_b
);

   localparam logic [15:0] HALF = PERIOD_CYC >> 1;
   localparam logic [15:0] LAST = PERIOD_CYC - 16'h0001;

   // ****************************************************************
   // apb register file
   // ****************************************************************
   logic        en_q,     en_d;
   logic [1:0]  rmode_q,  rmode_d;   // requested rectifier mode
   logic [15:0] phreq_q,  phreq_d;
   logic [15:0] dbareq_q, dbareq_d;
   logic [15:0] dbpreq_q, dbpreq_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;

   // pwm state, declared early for status reads
   logic        run_q,  run_d;
   logic [15:0] cnt_q,  cnt_d;
   logic [15:0] ph_q,   ph_d;
   logic [15:0] dba_q,  dba_d;
   logic [15:0] dbp_q,  dbp_d;
   logic [1:0]  mode_q, mode_d;
   logic [15:0] rcnt_q, rcnt_d;
   logic        rdn_q,  rdn_d;

   // next register values: one wait state, writes at the pready edge
   always_comb begin : apb_next
      en_d      = en_q;
      rmode_d   = rmode_q;
      phreq_d   = phreq_q;
      dbareq_d  = dbareq_q;
      dbpreq_d  = dbpreq_q;
      prdata_d  = prdata_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      if (psel && penable && !pready_q) begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         case (paddr)
            PSBP_OFF_CTRL: begin
               prdata_d[PSBP_CTRL_EN_BIT] = en_q;
               prdata_d[PSBP_CTRL_MODE_LSB +: 2] = rmode_q;
            end
            PSBP_OFF_PHASE:  prdata_d[15:0] = phreq_q;
            PSBP_OFF_DB_AP:  prdata_d[15:0] = dbareq_q;
            PSBP_OFF_DB_PA:  prdata_d[15:0] = dbpreq_q;
            PSBP_OFF_STATUS: begin
               prdata_d[PSBP_STAT_MODE_LSB +: 2] = mode_q;
               prdata_d[PSBP_STAT_RUN_BIT]       = run_q;
               prdata_d[PSBP_STAT_CNT_LSB +: 16] = cnt_q;
            end
            PSBP_OFF_RCNT:   prdata_d[15:0] = rcnt_q;
            default:         pslverr_d = 1'b1;
         endcase
      end
      if (psel && penable && pready_q && pwrite) begin
         case (paddr)
            PSBP_OFF_CTRL: begin
               en_d = pwdata[PSBP_CTRL_EN_BIT];
               if (pwdata[PSBP_CTRL_MODE_LSB +: 2] != 2'h3) begin
                  rmode_d = pwdata[PSBP_CTRL_MODE_LSB +: 2];
               end
            end
            PSBP_OFF_PHASE:
               phreq_d = (pwdata > {16'h0000, PERIOD_CYC}) ?
                         PERIOD_CYC : pwdata[15:0];
            PSBP_OFF_DB_AP:
               dbareq_d = (pwdata >= {16'h0000, HALF}) ?
                          HALF - 16'h0001 : pwdata[15:0];
            PSBP_OFF_DB_PA:
               dbpreq_d = (pwdata >= {16'h0000, HALF}) ?
                          HALF - 16'h0001 : pwdata[15:0];
            default: ;
         endcase
      end
   end

   // register stage of the bus slave
   always_ff @(posedge pclk or negedge presetn) begin : apb_regs
      if (!presetn) begin
         en_q      <= 1'b0;
         rmode_q   <= PSBP_RECT_OFF;
         phreq_q   <= PSBP_RST_PHASE;
         dbareq_q  <= PSBP_RST_DB;
         dbpreq_q  <= PSBP_RST_DB;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         en_q      <= en_d;
         rmode_q   <= rmode_d;
         phreq_q   <= phreq_d;
         dbareq_q  <= dbareq_d;
         dbpreq_q  <= dbpreq_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ****************************************************************
   // time bases and gate drives
   // ****************************************************************
   logic        ea_q, eb_q, sa_q, sb_q, ra_q, rb_q;
   logic        ea_d, eb_d, sa_d, sb_d, ra_d, rb_d;
   logic        bound;
   logic [16:0] ssum;
   logic [15:0] scnt;
   logic        pair1, pair2;

   // counters, shadows, and drive levels for the next cycle
   always_comb begin : pwm_next
      run_d = en_q;
      bound = run_q && (cnt_q == LAST);
      cnt_d = (!run_q || bound) ? 16'h0000 : cnt_q + 16'h0001;
      if (!run_q || bound) begin
         ph_d   = phreq_q;
         dba_d  = dbareq_q;
         dbp_d  = dbpreq_q;
         mode_d = rmode_q;
      end else begin
         ph_d   = ph_q;
         dba_d  = dba_q;
         dbp_d  = dbp_q;
         mode_d = mode_q;
      end
      ssum = {1'b0, cnt_d} + {1'b0, ph_d};
      if (ssum >= {1'b0, PERIOD_CYC}) begin
         ssum = ssum - {1'b0, PERIOD_CYC};
      end
      scnt = ssum[15:0];
      // end leg with its dead time
      ea_d = run_d && (cnt_d >= dba_d) && (cnt_d < HALF);
      eb_d = run_d && (cnt_d >= HALF + dba_d);
      // start leg with its dead time
      sa_d = run_d && (scnt >= dbp_d) && (scnt < HALF);
      sb_d = run_d && (scnt >= HALF + dbp_d);
      pair1 = sa_d && eb_d;
      pair2 = sb_d && ea_d;
      case (mode_d)
         PSBP_RECT_DIODE: begin
            ra_d = pair1;
            rb_d = pair2;
         end
         PSBP_RECT_FULL: begin
            ra_d = run_d && !pair2;
            rb_d = run_d && !pair1;
         end
         default: begin
            ra_d = 1'b0;
            rb_d = 1'b0;
         end
      endcase
      rcnt_d = rcnt_q;
      rdn_d  = rdn_q;
      if (!run_q || bound) begin
         rcnt_d = 16'h0000;
         rdn_d  = 1'b0;
      end else if (!rdn_q) begin
         rcnt_d = rcnt_q + 16'h0001;
         rdn_d  = (rcnt_q + 16'h0001 == HALF);
      end else begin
         rcnt_d = rcnt_q - 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin : pwm_regs
      if (!presetn) begin
         run_q  <= 1'b0;
         cnt_q  <= 16'h0000;
         ph_q   <= PSBP_RST_PHASE;
         dba_q  <= PSBP_RST_DB;
         dbp_q  <= PSBP_RST_DB;
         mode_q <= PSBP_RECT_OFF;
         rcnt_q <= 16'h0000;
         rdn_q  <= 1'b0;
         ea_q   <= 1'b0;
         eb_q   <= 1'b0;
         sa_q   <= 1'b0;
         sb_q   <= 1'b0;
         ra_q   <= 1'b0;
         rb_q   <= 1'b0;
      end else begin
         run_q  <= run_d;
         cnt_q  <= cnt_d;
         ph_q   <= ph_d;
         dba_q  <= dba_d;
         dbp_q  <= dbp_d;
         mode_q <= mode_d;
         rcnt_q <= rcnt_d;
         rdn_q  <= rdn_d;
         ea_q   <= ea_d;
         eb_q   <= eb_d;
         sa_q   <= sa_d;
         sb_q   <= sb_d;
         ra_q   <= ra_d;
         rb_q   <= rb_d;
      end
   end

   assign end_leg_drive_a   = ea_q;
   assign end_leg_drive_b   = eb_q;
   assign start_leg_drive_a = sa_q;
   assign start_leg_drive_b = sb_q;
   assign rect_drive_a      = ra_q;
   assign rect_drive_b      = rb_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_END_COMPL: assert property (!(ea_q && eb_q))
      else $error("end leg drives on together");
   AST_START_COMPL: assert property (!(sa_q && sb_q))
      else $error("start leg drives on together");
   AST_END_DEAD: assert property (
      ($fell(ea_q) && dba_q != 16'h0000 && run_q) |-> !eb_q)
      else $error("end leg dead time missing");
   AST_PERIOD: assert property (
      (run_q && cnt_q == LAST && en_q) |=> (cnt_q == 16'h0000) ##1
      (cnt_q == 16'h0001))
      else $error("period wrap wrong");
   AST_PHASE_CLAMP: assert property (ph_q <= PERIOD_CYC)
      else $error("phase beyond one period");
   AST_MODE_EDGE: assert property ($changed(mode_q) |-> cnt_q == 16'h0000)
      else $error("rectifier mode changed mid period");
   AST_MODE0: assert property (
      (mode_q == PSBP_RECT_OFF) |-> !(ra_q || rb_q))
      else $error("rectifier on in mode 0");
   AST_MODE1: assert property (
      (mode_q == PSBP_RECT_DIODE && run_q) |->
      (ra_q == (sa_q && eb_q)) && (rb_q == (sb_q && ea_q)))
      else $error("mode 1 rectifier gating wrong");
   AST_MODE2: assert property (
      (mode_q == PSBP_RECT_FULL && run_q) |->
      (ra_q == !(sb_q && ea_q)) && (rb_q == !(sa_q && eb_q)))
      else $error("mode 2 rectifier gating wrong");
   AST_IDLE_OFF: assert property (
      !run_q |-> !(ea_q || eb_q || sa_q || sb_q || ra_q || rb_q))
      else $error("drive active while stopped");
   // up-down base must mirror the up counter
   AST_RCNT_SHAPE: assert property (
      run_q |-> rcnt_q == ((cnt_q <= HALF) ? cnt_q : PERIOD_CYC - cnt_q))
      else $error("rectifier base out of step");

   COV_MODE1_PULSE: cover property (mode_q == PSBP_RECT_DIODE && $rose(ra_q));
   COV_MODE2_RUN:   cover property (mode_q == PSBP_RECT_FULL && $fell(rb_q));
   COV_MODE_SWAP:   cover property (run_q && $changed(mode_q));
   COV_PHASE_UPD:   cover property (run_q && $changed(ph_q));

endmodule : psbp_core
`default_nettype wire

// *** tb/psbp_gate_model.sv ***
/*
 * gate driver model for the four bridge switches and two rectifiers.
 * assumes drives are high=on and are looked at on rising pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module psbp_gate_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        end_leg_drive_a,
   input  wire logic        end_leg_drive_b,
   input  wire logic        start_leg_drive_a,
   input  wire logic        start_leg_drive_b,
   input  wire logic        rect_drive_a,
   input  wire logic        rect_drive_b,
   output logic      [15:0] overlap_q,
   output logic      [15:0] rect_on_q
);
   // ****************************************************************
   // switch states and shoot-through count
   // ****************************************************************
   logic        sw_e1, sw_e2, sw_s1, sw_s2, sw_r1, sw_r2;
   logic [15:0] overlap_d;
   logic [15:0] rect_on_d;

   assign sw_e1 = end_leg_drive_a;
   assign sw_e2 = end_leg_drive_b;
   assign sw_s1 = start_leg_drive_a;
   assign sw_s2 = start_leg_drive_b;
   assign sw_r1 = rect_drive_a;
   assign sw_r2 = rect_drive_b;

   always_comb begin
      overlap_d = overlap_q;
      rect_on_d = rect_on_q;
      if ((sw_e1 && sw_e2) || (sw_s1 && sw_s2)) begin
         overlap_d = overlap_q + 16'h0001;
      end
      if (sw_r1 || sw_r2) begin
         rect_on_d = rect_on_q + 16'h0001;
      end
   end

   // count register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlap_q <= 16'h0000;
         rect_on_q <= 16'h0000;
      end else begin
         overlap_q <= overlap_d;
         rect_on_q <= rect_on_d;
      end
   end
endmodule : psbp_gate_model
`default_nettype wire

// *** tb/tb_phase_shift_bridge_pwm.sv ***
/*
 * self-checking bench: apb master, cycle reference of the drives.
 * assumes psbp_core with a 40 cycle period; the master waits for pready.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_phase_shift_bridge_pwm
   import psbp_pkg::*;
;
   localparam int P = 40;
   localparam int H = P / 2;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        ea, eb, sa, sb, ra, rb, m_en, m_run;
   logic [15:0] overlap, rect_on;
   logic [1:0]  r_md, s_md;
   int          miscompares, n_checks, m_cnt;
   int          r_ph, r_da, r_dp, s_ph, s_da, s_dp;

   always #12.5 pclk = ~pclk;

   psbp_core #(.PERIOD_CYC(16'h0028)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .end_leg_drive_a(ea),
      .end_leg_drive_b(eb), .start_leg_drive_a(sa),
      .start_leg_drive_b(sb), .rect_drive_a(ra), .rect_drive_b(rb));

   psbp_gate_model u_gate (
      .pclk(pclk), .presetn(presetn), .end_leg_drive_a(ea),
      .end_leg_drive_b(eb), .start_leg_drive_a(sa),
      .start_leg_drive_b(sb), .rect_drive_a(ra), .rect_drive_b(rb),
      .overlap_q(overlap), .rect_on_q(rect_on));

   // ****************************************************************
   // reference drives and comparison
   // ****************************************************************
   function automatic logic [5:0] exp_drv(int c);
      int   ph, da, dp, s;
      logic xa, xb, ya, yb;
      ph = (s_ph > P) ? P : s_ph;
      da = (s_da >= H) ? H - 1 : s_da;
      dp = (s_dp >= H) ? H - 1 : s_dp;
      s = (c + ph) % P;
      xa = c >= da && c < H;
      xb = c >= H + da;
      ya = s >= dp && s < H;
      yb = s >= H + dp;
      if (!m_run) return 6'h00;
      case (s_md)
         2'h1: return {xa, xb, ya, yb, ya & xb, yb & xa};
         2'h2: return {xa, xb, ya, yb, ~(yb & xa), ~(ya & xb)};
         default: return {xa, xb, ya, yb, 2'h0};
      endcase
   endfunction : exp_drv

   task check(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // per-cycle drive check; the model steps like the design's registers
   always @(posedge pclk) begin
      #2;
      check("drives", {26'h0, exp_drv(m_cnt)},
            {26'h0, ea, eb, sa, sb, ra, rb});
      // shadows load while stopped or at the period wrap
      if (!m_run || m_cnt == P - 1) begin
         m_cnt = 0;
         s_ph = r_ph;
         s_da = r_da;
         s_dp = r_dp;
         s_md = r_md;
      end else begin
         m_cnt = m_cnt + 1;
      end
      // run follows the enable bit one cycle late
      m_run = m_en;
   end

   // model side effects of a stored write
   task model_upd(logic [7:0] a, logic [31:0] d);
      case (a)
         PSBP_OFF_CTRL: begin
            if (d[PSBP_CTRL_MODE_LSB +: 2] != 2'h3) begin
               r_md = d[PSBP_CTRL_MODE_LSB +: 2];
            end
            m_en = d[PSBP_CTRL_EN_BIT];
         end
         PSBP_OFF_PHASE: r_ph = d[15:0];
         PSBP_OFF_DB_AP: r_da = d[15:0];
         PSBP_OFF_DB_PA: r_dp = d[15:0];
         default: ;
      endcase
   endtask : model_upd

   // model state right after a reset
   task model_rst();
      m_en = 1'b0;
      m_run = 1'b0;
      m_cnt = 0;
      r_ph = PSBP_RST_PHASE;
      r_da = PSBP_RST_DB;
      r_dp = PSBP_RST_DB;
      r_md = PSBP_RECT_OFF;
      s_ph = r_ph;
      s_da = r_da;
      s_dp = r_dp;
      s_md = r_md;
   endtask : model_rst

   // ****************************************************************
   // apb master
   // ****************************************************************
   task apb(logic wr, logic [7:0] a, logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int i;
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge pclk); i++; end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin miscompares++; results(); end
      if (wr) model_upd(a, d);
      @(posedge pclk);
   endtask : apb

   task wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask : wr

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task reset_vals();
      logic [31:0] x;
      logic        e;
      apb(1'b0, PSBP_OFF_CTRL, 0, x, e); check("ctrl", 0, x);
      apb(1'b0, PSBP_OFF_PHASE, 0, x, e); check("phase", 0, x);
      apb(1'b0, PSBP_OFF_DB_AP, 0, x, e); check("db_ap", 8, x);
      apb(1'b0, PSBP_OFF_DB_PA, 0, x, e); check("db_pa", 8, x);
      apb(1'b0, 8'h18, 0, x, e); check("unmapped", 0, x);
      check("slverr", 1, {31'h0, e});
   endtask : reset_vals

   task run_cfg(int ph, int da, int dp, logic [1:0] md, logic [1:0] cm);
      logic [31:0] x;
      logic        e;
      logic [15:0] rc0;
      wr(PSBP_OFF_CTRL, {29'h0, md, 1'b0});
      wr(PSBP_OFF_PHASE, ph);
      wr(PSBP_OFF_DB_AP, da);
      wr(PSBP_OFF_DB_PA, dp);
      rc0 = rect_on;
      wr(PSBP_OFF_CTRL, {29'h0, cm, 1'b1});
      repeat (3 * P) @(posedge pclk);
      check("rect_used", {31'h0, md != 2'h0},
            {31'h0, rect_on != rc0});
      apb(1'b0, PSBP_OFF_STATUS, 0, x, e);
      check("status", {1'b1, md}, x[2:0]);
   endtask : run_cfg

   task mid_run();
      wr(PSBP_OFF_CTRL, 32'h0000_0003);
      // loop hand-over moves only the phase command
      wr(PSBP_OFF_PHASE, 35);
      repeat (3 * P) @(posedge pclk);
      // direction hand-over is a plain stop here
      wr(PSBP_OFF_CTRL, 0);
      repeat (5) @(posedge pclk);
   endtask : mid_run

   // reset while running, drives must drop at once
   task reset_mid();
      logic [31:0] x;
      logic        e;
      wr(PSBP_OFF_CTRL, 32'h0000_0005);
      repeat (P + 7) @(posedge pclk);
      check("overlap_run", 0, {16'h0, overlap});
      presetn <= 1'b0;
      model_rst();
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PSBP_OFF_PHASE, 0, x, e);
      check("phase_rst", 0, x);
   endtask : reset_mid

   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      miscompares = 0; n_checks = 0;
      model_rst();
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_vals();
      run_cfg(10, 2, 3, 2'h0, 2'h0);
      run_cfg(25, 8, 5, 2'h1, 2'h1);
      run_cfg(50, 30, 0, 2'h2, 2'h2);
      run_cfg(12, 4, 4, 2'h2, 2'h3);
      mid_run();
      check("overlap", 0, {16'h0, overlap});
      reset_mid();
      results();
   end
endmodule : tb_phase_shift_bridge_pwm
`default_nettype wire
